// ### verilog/fpcr_consts.vh
// Constants of the filter path configuration register bank.
// Assumes inclusion by bare name from the bank's design files.
`ifndef FPCR_CONSTS_VH
`define FPCR_CONSTS_VH

// Register addresses on the serial control port.
`define FPCR_ADDR_ROUTING    7'h05
`define FPCR_ADDR_POWER2     7'h12
`define FPCR_ADDR_IMODE      7'h14

// Reset values.
`define FPCR_RST_ROUTING     6'h00
`define FPCR_RST_POWER2      8'h00
`define FPCR_RST_IMODE       6'h00

// Field positions of the routing register.
`define FPCR_RT_SRC_HI       5
`define FPCR_RT_SRC_LO       4
`define FPCR_RT_ORDER        3
`define FPCR_RT_SW2          2
`define FPCR_RT_AMUX_HI      1
`define FPCR_RT_AMUX_LO      0
`define FPCR_RT_STORED_HI    5

// Encodings of the filter source and amplifier multiplexer fields.
`define FPCR_SRC_PIN         2'h0
`define FPCR_SRC_AMPMUX      2'h1
`define FPCR_SRC_OPAMP2      2'h2
`define FPCR_AMUX_OPEN       2'h0
`define FPCR_AMUX_CH1        2'h1
`define FPCR_AMUX_CH2        2'h2
`define FPCR_AMUX_CH3        2'h3

// Field positions of the second power control register.
`define FPCR_PC_CONV7        7
`define FPCR_PC_CONV6        6
`define FPCR_PC_CONV5        5
`define FPCR_PC_OPAMP2       4
`define FPCR_PC_LOWPASS      3
`define FPCR_PC_HIGHPASS     2
`define FPCR_PC_REGULATOR    1
`define FPCR_PC_TEMP         0

// Field positions of the input mode register.
`define FPCR_IM_FILTER       5
`define FPCR_IM_STORED_HI    5

// Serial frame: read flag, seven address bits, eight data bits.
`define FPCR_CMD_READ        7
`define FPCR_BIT_LAST        3'h7
`define FPCR_BYTE_ZERO       8'h00

`endif

// ### verilog/fpcr_clk_halver.v
// Divides an external filter clock by two into a 50% duty sampling clock.
// Assumes the external clock is far slower than sys_clk (below sys_clk/4).
`timescale 1ns/1ps
module fpcr_clk_halver (
    input  wire sys_clk,
    input  wire rst,
    input  wire run,
    input  wire ext_clk,
    output reg  samp_clk
);
    reg ext_meta;
    reg ext_sync;
    reg ext_prev;

    always @(posedge sys_clk) begin
        if (rst) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
            samp_clk <= 1'b0;
        end else begin
            ext_meta <= ext_clk;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
            // The halving flip-flop toggles on each rising edge while run.
            if (!run) begin
                samp_clk <= 1'b0;
            end else if (ext_sync && !ext_prev) begin
                samp_clk <= ~samp_clk;
            end
        end
    end
endmodule

// ### verilog/fpcr_top.v
// Filter path configuration register bank behind a serial control port.
// Assumes the host drives mode 0 frames with sck below sys_clk/8.
//
// Contract
// - Routing register at 05H, read/write byte, reset to zero.
// - Source field 5:4 picks pin, amp mux or op-amp 2; 11 forbidden.
// - Order bit 3: 0 low-pass then high-pass, 1 high-pass first.
// - Amp mux field 1:0: open, or amplifier channel 1, 2, 3.
// - Bits 7:6 of routing and input mode accept ones, no effect.
// - Second power control register at 12H, read/write, reset to zero.
// - Bit 3 runs the low-pass filter; host sets it before use.
// - Bit 2 runs the high-pass filter; host sets it before use.
// - Other power bits run converters 7-5, op-amp 2, regulator, sensor.
// - Input mode register at 14H, read/write byte, reset to zero.
// - Input mode bit 5 is shared by both filters; host programs it.
// - Each filter halves its external clock in a flip-flop, 50% duty.
// - Filter input mode 0 is rail-to-rail, 1 is P-channel single-ended.
`timescale 1ns/1ps
`include "fpcr_consts.vh"
module fpcr_top (
    input  wire       sys_clk,
    input  wire       rst,
    input  wire       spi_sck,
    input  wire       spi_cs_n,
    input  wire       spi_mosi,
    output reg        spi_miso,
    output wire       spi_miso_oe_n,
    input  wire       lowpass_clock_pin,
    input  wire       highpass_clock_pin,
    output wire       lowpass_samp_clk,
    output wire       highpass_samp_clk,
    output wire [1:0] filter_source,
    output wire       src_sel_input_pin,
    output wire       src_sel_amp_mux,
    output wire       src_sel_opamp2,
    output wire       filter_order,
    output wire       chain_lowpass_first,
    output wire       chain_highpass_first,
    output wire       routing_switch_bit2,
    output wire [1:0] amp_mux_sel,
    output wire [2:0] amp_mux_onehot,
    output wire       converter7_enable,
    output wire       converter6_enable,
    output wire       converter5_enable,
    output wire       opamp2_enable,
    output wire       lowpass_enable,
    output wire       highpass_enable,
    output wire       regulator_enable,
    output wire       temp_sensor_enable,
    output wire       filter_input_mode,
    output wire       filter_input_pch,
    output wire [4:0] amp_input_modes
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_ADDR = 4'h2;
    localparam [3:0] ST_DATA = 4'h4;
    localparam [3:0] ST_DONE = 4'h8;

    reg [5:0] filter_routing;
    reg [7:0] power_control_second;
    reg [5:0] input_mode_select;

    reg       sck_meta;
    reg       sck_sync;
    reg       sck_prev;
    reg       cs_meta;
    reg       cs_sync;
    reg       mosi_meta;
    reg       mosi_sync;

    reg [3:0] state;
    reg [2:0] bit_cnt;
    reg [7:0] cmd;
    reg [7:0] shift_in;
    reg [7:0] shift_out;

    wire      sck_rise;
    wire      sck_fall;
    wire [7:0] next_cmd;
    wire [7:0] next_shift_in;

    // Read view of the bank; unmapped addresses read as zero.
    function [7:0] read_mux;
        input [6:0] addr;
        input [5:0] routing;
        input [7:0] power;
        input [5:0] imode;
        begin
            case (addr)
                `FPCR_ADDR_ROUTING: read_mux = {2'h0, routing};
                `FPCR_ADDR_POWER2:  read_mux = power;
                `FPCR_ADDR_IMODE:   read_mux = {2'h0, imode};
                default:            read_mux = `FPCR_BYTE_ZERO;
            endcase
        end
    endfunction

    assign sck_rise      = sck_sync & ~sck_prev & ~cs_sync;
    assign sck_fall      = ~sck_sync & sck_prev & ~cs_sync;
    assign next_cmd      = {cmd[6:0], mosi_sync};
    assign next_shift_in = {shift_in[6:0], mosi_sync};
    assign spi_miso_oe_n = cs_sync;

    always @(posedge sys_clk) begin
        if (rst) begin
            sck_meta  <= 1'b0;
            sck_sync  <= 1'b0;
            sck_prev  <= 1'b0;
            cs_meta   <= 1'b1;
            cs_sync   <= 1'b1;
            mosi_meta <= 1'b0;
            mosi_sync <= 1'b0;
        end else begin
            sck_meta  <= spi_sck;
            sck_sync  <= sck_meta;
            sck_prev  <= sck_sync;
            cs_meta   <= spi_cs_n;
            cs_sync   <= cs_meta;
            mosi_meta <= spi_mosi;
            mosi_sync <= mosi_meta;
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            state                <= ST_IDLE;
            bit_cnt              <= 3'h0;
            cmd                  <= `FPCR_BYTE_ZERO;
            shift_in             <= `FPCR_BYTE_ZERO;
            shift_out            <= `FPCR_BYTE_ZERO;
            spi_miso             <= 1'b0;
            filter_routing       <= `FPCR_RST_ROUTING;
            power_control_second <= `FPCR_RST_POWER2;
            input_mode_select    <= `FPCR_RST_IMODE;
        end else if (cs_sync) begin
            // Deselect ends any frame; a partial frame writes nothing.
            state    <= ST_IDLE;
            bit_cnt  <= 3'h0;
            spi_miso <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    state     <= ST_ADDR;
                    bit_cnt   <= 3'h0;
                    shift_out <= `FPCR_BYTE_ZERO;
                end
                ST_ADDR: begin
                    if (sck_rise) begin
                        cmd     <= next_cmd;
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == `FPCR_BIT_LAST) begin
                            state     <= ST_DATA;
                            shift_out <= read_mux(next_cmd[6:0],
                                filter_routing, power_control_second,
                                input_mode_select);
                        end
                    end
                end
                ST_DATA: begin
                    if (sck_fall) begin
                        spi_miso  <= cmd[`FPCR_CMD_READ] & shift_out[7];
                        shift_out <= {shift_out[6:0], 1'b0};
                    end
                    if (sck_rise) begin
                        shift_in <= next_shift_in;
                        bit_cnt  <= bit_cnt + 3'h1;
                        if (bit_cnt == `FPCR_BIT_LAST) begin
                            state <= ST_DONE;
                            if (!cmd[`FPCR_CMD_READ]) begin
                                case (cmd[6:0])
                                    `FPCR_ADDR_ROUTING: begin
                                        // Bits 7:6 are dropped here.
                                        filter_routing <= next_shift_in
                                        [`FPCR_RT_STORED_HI:0];
                                    end
                                    `FPCR_ADDR_POWER2: begin
                                        power_control_second <=
                                            next_shift_in;
                                    end
                                    `FPCR_ADDR_IMODE: begin
                                        // Bits 7:6 are dropped here.
                                        input_mode_select <= next_shift_in
                                        [`FPCR_IM_STORED_HI:0];
                                    end
                                    default: begin
                                        filter_routing <= filter_routing;
                                    end
                                endcase
                            end
                        end
                    end
                end
                ST_DONE: begin
                    if (sck_fall) begin
                        spi_miso <= 1'b0;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Routing decode; the forbidden source code 11 selects nothing.
    assign filter_source = {filter_routing[`FPCR_RT_SRC_HI],
                            filter_routing[`FPCR_RT_SRC_LO]};
    assign src_sel_input_pin = (filter_source == `FPCR_SRC_PIN);
    assign src_sel_amp_mux = (filter_source == `FPCR_SRC_AMPMUX);
    assign src_sel_opamp2 = (filter_source == `FPCR_SRC_OPAMP2);

    assign filter_order         = filter_routing[`FPCR_RT_ORDER];
    assign chain_lowpass_first  = ~filter_order;
    assign chain_highpass_first = filter_order;
    assign routing_switch_bit2  = filter_routing[`FPCR_RT_SW2];

    assign amp_mux_sel = {filter_routing[`FPCR_RT_AMUX_HI],
                          filter_routing[`FPCR_RT_AMUX_LO]};
    assign amp_mux_onehot = {amp_mux_sel == `FPCR_AMUX_CH3,
                             amp_mux_sel == `FPCR_AMUX_CH2,
                             amp_mux_sel == `FPCR_AMUX_CH1};

    assign converter7_enable =
        power_control_second[`FPCR_PC_CONV7];
    assign converter6_enable =
        power_control_second[`FPCR_PC_CONV6];
    assign converter5_enable =
        power_control_second[`FPCR_PC_CONV5];
    assign opamp2_enable =
        power_control_second[`FPCR_PC_OPAMP2];
    assign lowpass_enable =
        power_control_second[`FPCR_PC_LOWPASS];
    assign highpass_enable =
        power_control_second[`FPCR_PC_HIGHPASS];
    assign regulator_enable =
        power_control_second[`FPCR_PC_REGULATOR];
    assign temp_sensor_enable =
        power_control_second[`FPCR_PC_TEMP];

    assign filter_input_mode = input_mode_select[`FPCR_IM_FILTER];
    assign filter_input_pch  = filter_input_mode;
    assign amp_input_modes   = input_mode_select[4:0];

    // A stopped filter holds its sampling clock low.
    fpcr_clk_halver u_lowpass_halver (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .run      (lowpass_enable),
        .ext_clk  (lowpass_clock_pin),
        .samp_clk (lowpass_samp_clk)
    );

    fpcr_clk_halver u_highpass_halver (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .run      (highpass_enable),
        .ext_clk  (highpass_clock_pin),
        .samp_clk (highpass_samp_clk)
    );
endmodule

// ### tb/fpcr_host.sv
// Host model: serial control frames and the two external filter clocks.
// Assumes sys_clk from the bench; frames are driven at its falling edge.
`timescale 1ns/1ps
module fpcr_host (
    input  wire sys_clk,
    input  wire miso,
    output reg  sck,
    output reg  cs_n,
    output reg  mosi,
    output reg  lp_clk,
    output reg  hp_clk
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        lp_clk = 1'b0;
        hp_clk = 1'b0;
        repeat (100) @(negedge sys_clk);
        forever begin
            repeat (313) @(negedge sys_clk);
            hp_clk <= ~hp_clk;
        end
    end
    always begin
        repeat (313) @(negedge sys_clk);
        lp_clk <= ~lp_clk;
    end
    // Sends the top nbits of frame; read data is the last eight bits seen.
    task automatic xfer(input [15:0] frame, input integer nbits,
                        output [7:0] rdv);
        integer i;
        begin
            rdv = 8'h00;
            @(negedge sys_clk) cs_n <= 1'b0;
            repeat (3) @(negedge sys_clk);
            for (i = 15; i > 15 - nbits; i = i - 1) begin
                mosi <= frame[i];
                repeat (5) @(negedge sys_clk);
                sck <= 1'b1;
                rdv = {rdv[6:0], miso};
                repeat (5) @(negedge sys_clk);
                sck <= 1'b0;
            end
            repeat (5) @(negedge sys_clk);
            cs_n <= 1'b1;
            mosi <= ~mosi;
            repeat (4) @(negedge sys_clk);
        end
    endtask
endmodule

// ### tb/fpcr_checker_sva.sv
// Port checks of the filter path configuration bank.
// Assumes a bind to fpcr_top; one clock sys_clk, reset rst.
`timescale 1ns/1ps
module fpcr_checker (
    input wire       sys_clk,
    input wire       rst,
    input wire       spi_cs_n,
    input wire       spi_miso_oe_n,
    input wire       lowpass_clock_pin,
    input wire       highpass_clock_pin,
    input wire       lowpass_samp_clk,
    input wire       highpass_samp_clk,
    input wire [1:0] filter_source,
    input wire       src_sel_input_pin,
    input wire       src_sel_amp_mux,
    input wire       src_sel_opamp2,
    input wire       filter_order,
    input wire       chain_lowpass_first,
    input wire       chain_highpass_first,
    input wire [1:0] amp_mux_sel,
    input wire [2:0] amp_mux_onehot,
    input wire       lowpass_enable,
    input wire       highpass_enable,
    input wire       filter_input_mode,
    input wire       filter_input_pch
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence lp_edge;
        $rose(lowpass_clock_pin) && lowpass_enable;
    endsequence
    sequence hp_edge;
        $rose(highpass_clock_pin) && highpass_enable;
    endsequence
    src_decode_a: assert property (
        {src_sel_opamp2, src_sel_amp_mux, src_sel_input_pin} ==
        {filter_source == 2'h2, filter_source == 2'h1, filter_source == 2'h0})
        else $error("source decode wrong");
    order_decode_a: assert property (
        chain_lowpass_first == !filter_order &&
        chain_highpass_first == filter_order) else $error("order wrong");
    amux_decode_a: assert property (
        amp_mux_onehot == {amp_mux_sel == 2'h3, amp_mux_sel == 2'h2,
        amp_mux_sel == 2'h1}) else $error("amp mux decode wrong");
    mode_decode_a: assert property (
        filter_input_pch == filter_input_mode) else $error("mode wrong");
    reset_clear_a: assert property (disable iff (1'b0) rst |=>
        filter_source == 2'h0 && !filter_order && amp_mux_sel == 2'h0 &&
        !lowpass_enable && !highpass_enable && !filter_input_mode)
        else $error("reset values wrong");
    lp_stop_a: assert property (
        !lowpass_enable |=> !lowpass_samp_clk) else $error("lp runs");
    hp_stop_a: assert property (
        !highpass_enable |=> !highpass_samp_clk) else $error("hp runs");
    lp_half_a: assert property (lp_edge |-> ##[1:6]
        ($changed(lowpass_samp_clk) || !lowpass_enable))
        else $error("lp sample clock missed an edge");
    hp_half_a: assert property (hp_edge |-> ##[1:6]
        ($changed(highpass_samp_clk) || !highpass_enable))
        else $error("hp sample clock missed an edge");
    oe_low_a: assert property (
        $fell(spi_cs_n) |-> ##2 !spi_miso_oe_n)
        else $error("miso enable not low in frame");
    oe_high_a: assert property (
        $rose(spi_cs_n) |-> ##2 spi_miso_oe_n)
        else $error("miso enable not high after frame");
endmodule
bind fpcr_top fpcr_checker u_checker (.*);

// ### tb/filter_path_config_regs_bench.sv
// Self-checking bench of the filter path configuration bank.
// Assumes fpcr_top, fpcr_host and the bound checker are compiled first.
`timescale 1ns/1ps
module filter_path_config_regs_bench;
    reg        sys_clk = 1'b0;
    reg        rst = 1'b1;
    wire       spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
    wire       lowpass_clock_pin, highpass_clock_pin, filter_order;
    wire       lowpass_samp_clk, highpass_samp_clk, routing_switch_bit2;
    wire [1:0] filter_source, amp_mux_sel;
    wire       src_sel_input_pin, src_sel_amp_mux, src_sel_opamp2;
    wire       chain_lowpass_first, chain_highpass_first;
    wire       filter_input_mode, filter_input_pch, opamp2_enable;
    wire [2:0] amp_mux_onehot;
    wire       converter7_enable, converter6_enable, converter5_enable;
    wire       lowpass_enable, highpass_enable;
    wire       regulator_enable, temp_sensor_enable;
    wire [4:0] amp_input_modes;
    integer    failures, checked, i, lp_tog = 0, hp_tog = 0, n0, m0;
    reg  [7:0] v, v2, v3;
    // Rows: address, byte written, byte read back. No row writes source 11.
    reg [23:0] rows [0:8] = '{24'h05D919, 24'h052E2E, 24'h050303,
        24'h050000, 24'h12A5A5, 24'h125A5A, 24'h14E020, 24'h141F1F,
        24'h13FF00};
    fpcr_top u_dut (.*);
    fpcr_host u_host (.sys_clk(sys_clk), .miso(spi_miso), .sck(spi_sck),
        .cs_n(spi_cs_n), .mosi(spi_mosi), .lp_clk(lowpass_clock_pin),
        .hp_clk(highpass_clock_pin));
    always #4 sys_clk = ~sys_clk;
    always @(lowpass_samp_clk) lp_tog = lp_tog + 1;
    always @(highpass_samp_clk) hp_tog = hp_tog + 1;
    task cmp(input [23:0] seen, input [23:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("CHECK FAILED %0t: saw %h, want %h",
                    $time, seen, exp);
            end
        end
    endtask
    task wr(input [6:0] a, input [7:0] d);
        u_host.xfer({1'b0, a, d}, 16, v3);
    endtask
    task rd(input [6:0] a, output [7:0] d);
        u_host.xfer({1'b1, a, 8'h00}, 16, d);
    endtask
    task summarize;
        begin
            if (failures == 0 && checked > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        failures = 0;
        checked = 0;
        repeat (4) @(negedge sys_clk);
        rst <= 1'b0;
        rd(7'h05, v);
        rd(7'h12, v2);
        rd(7'h14, v3);
        cmp({v, v2, v3}, 24'h000000);
        for (i = 0; i < 9; i = i + 1) begin
            wr(rows[i][22:16], rows[i][15:8]);
            rd(rows[i][22:16], v);
            cmp(v, rows[i][7:0]);
            if (rows[i][22:16] == 7'h05)
                cmp({filter_source, filter_order, routing_switch_bit2,
                    amp_mux_sel}, rows[i][5:0]);
            if (rows[i][22:16] == 7'h12)
                cmp({converter7_enable, converter6_enable, converter5_enable,
                    opamp2_enable, lowpass_enable, highpass_enable,
                    regulator_enable, temp_sensor_enable},
                    rows[i][7:0]);
            if (rows[i][22:16] == 7'h14)
                cmp({filter_input_mode, amp_input_modes},
                    rows[i][5:0]);
        end
        u_host.xfer({1'b0, 7'h05, 8'h1A}, 12, v);
        rd(7'h05, v);
        cmp(v, 8'h00);
        cmp(spi_miso_oe_n, 1'b1);
        wr(7'h14, 8'h20);
        rd(7'h12, v);
        wr(7'h12, v | 8'h0C);
        rd(7'h12, v2);
        cmp(v2, 8'h5E);
        @(posedge lowpass_clock_pin);
        n0 = lp_tog;
        m0 = hp_tog;
        repeat (4) @(posedge lowpass_clock_pin);
        cmp(lp_tog - n0, 24'd4);
        cmp(hp_tog - m0, 24'd4);
        wr(7'h12, v & 8'hF3);
        n0 = lp_tog;
        m0 = hp_tog;
        repeat (2) @(posedge lowpass_clock_pin);
        cmp(lp_tog - n0, 24'd0);
        cmp(hp_tog - m0, 24'd0);
        cmp({lowpass_samp_clk, highpass_samp_clk}, 24'h0);
        wr(7'h05, 8'h2E);
        rst <= 1'b1;
        repeat (4) @(negedge sys_clk);
        rst <= 1'b0;
        rd(7'h05, v);
        cmp(v, 8'h00);
        summarize;
    end
    initial begin
        #400000;
        failures = failures + 1;
        summarize;
    end
endmodule
